// *** rtl/fcdma_map.vh ***
/*
 * Constants for the four-channel transfer controller: widths, step codes
 * and reset values. Assumes inclusion by bare name from the design files.
 */
`ifndef FCDMA_MAP_VH
`define FCDMA_MAP_VH

`define FCDMA_NUM_CH 4
`define FCDMA_ADDR_W 24
`define FCDMA_LEN_W 16
`define FCDMA_DATA_W 16

// step codes of step_a_size / step_b_size
`define FCDMA_STEP_INC1 2'h0
`define FCDMA_STEP_INC2 2'h1
`define FCDMA_STEP_DEC1 2'h2
`define FCDMA_STEP_DEC2 2'h3

// reset values
`define FCDMA_ADDR_RST 24'h000000
`define FCDMA_LEN_RST 16'h0000
`define FCDMA_DATA_RST 16'h0000
`define FCDMA_FLAG_RST 4'h0

`endif

// *** rtl/fcdma_step.v ***
/*
 * Address step unit: computes the next value of one address counter.
 * Assumes the caller writes the result back only when an item completes.
 */
`include "fcdma_map.vh"

module fcdma_step (
    input wire [23:0] addr_in,
    input wire [1:0] step_in,
    input wire adjust_in,
    output reg [23:0] addr_out
);

    // freeze when adjust is off; step is independent of item size
    always @* begin
        addr_out = addr_in;
        if (adjust_in) begin
            case (step_in)
                `FCDMA_STEP_INC1: addr_out = addr_in + 24'h000001;
                `FCDMA_STEP_INC2: addr_out = addr_in + 24'h000002;
                `FCDMA_STEP_DEC1: addr_out = addr_in - 24'h000001;
                default: addr_out = addr_in - 24'h000002;
            endcase
        end
    end

endmodule

// *** rtl/fcdma_top.v ***
/*
 * Four-channel transfer controller core: request arbitration, bus
 * mastership, direct and indirect item moves, counters and status flags.
 * Assumes a zero-wait system bus that grants mastership via BUS_GRANT_IN
 * and on-chip requesters clocked by CORE_CLK_IN.
 */
// Overview of operation
// - requests come only from on-chip peripheral lines or software request bits
// - an enabled channel's request first wins the processor bus before any cycle
// - fixed priority, channel 0 highest, resolved one clock before first bus clock
// - acknowledge to a peripheral only during a direct bus cycle; indirect cycles raise none
// - on block end: update flags, raise interrupt if enabled, release the bus
// - continuous policy with request still high repeats; otherwise bus released
// - next request sampled as acknowledge drops, then on every rising edge
// - four channels 0 to 3, each with its own control set
// - direct: one bus cycle per item, no data latched, only address A used
// - intermittent returns bus after each item; continuous keeps it to block end
// - direct peak: one item per three clocks intermittent, per clock continuous
// - direct: sense clear reads addressed device, sense set writes it
// - item size 8 or 16 bits; per direct item length minus one, A steps
// - indirect: read into holding register, write it in the next bus cycle
// - indirect peak: one item per five clocks intermittent, per two continuous
// - indirect: sense 0 reads via A writes via B, sense set the reverse
// - per indirect item length minus one, both address counters step
// - single mode at length zero: stop, set done and overrun, clear active
// - debug halt suspends all transfers; they resume when halt drops
`include "fcdma_map.vh"

module fcdma_top (
    input wire CORE_CLK_IN,
    input wire ARST_N_IN,
    input wire HALT_IN,
    input wire [3:0] CH_ENABLE_IN,
    input wire [3:0] SRC_SEL_IN,
    input wire [3:0] HW_REQ_PRI_IN,
    input wire [3:0] HW_REQ_SEC_IN,
    input wire [3:0] SW_REQ_IN,
    input wire [3:0] INDIRECT_IN,
    input wire [3:0] CONTINUOUS_IN,
    input wire [3:0] SENSE_IN,
    input wire [3:0] ITEM16_IN,
    input wire [7:0] STEP_A_IN,
    input wire [7:0] STEP_B_IN,
    input wire [3:0] ADJ_A_IN,
    input wire [3:0] ADJ_B_IN,
    input wire [3:0] DONE_IRQ_EN_IN,
    input wire [3:0] OVR_IRQ_EN_IN,
    input wire [3:0] LOAD_IN,
    input wire [23:0] LOAD_ADDR_A_IN,
    input wire [23:0] LOAD_ADDR_B_IN,
    input wire [15:0] LOAD_LEN_IN,
    input wire [3:0] TC_CLR_IN,
    input wire [3:0] OVR_CLR_IN,
    input wire BUS_GRANT_IN,
    input wire [15:0] BUS_RDATA_IN,
    output wire BUS_REQ_OUT,
    output wire [23:0] BUS_ADDR_OUT,
    output wire BUS_RD_OUT,
    output wire BUS_WR_OUT,
    output wire BUS_WIDE_OUT,
    output wire BUS_DRIVE_OUT,
    output wire [15:0] BUS_WDATA_OUT,
    output wire [3:0] ACK_OUT,
    output wire [3:0] TC_FLAG_OUT,
    output wire [3:0] OVR_FLAG_OUT,
    output wire [3:0] ACTIVE_OUT,
    output wire [3:0] IRQ_OUT
);

    localparam S_ARB = 3'h0;
    localparam S_PRI = 3'h1;
    localparam S_XFER = 3'h2;
    localparam S_RD = 3'h3;
    localparam S_WR = 3'h4;
    localparam S_REL = 3'h5;

    // lowest-numbered pending channel wins
    function [1:0] fcdma_pick;
        input [3:0] pend;
        begin
            if (pend[0])
                fcdma_pick = 2'h0;
            else if (pend[1])
                fcdma_pick = 2'h1;
            else if (pend[2])
                fcdma_pick = 2'h2;
            else
                fcdma_pick = 2'h3;
        end
    endfunction

    reg rst_s1;
    reg rst_n;
    reg halt_s1;
    reg halt;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] cur;
    reg [23:0] addr_a [0:3];
    reg [23:0] addr_b [0:3];
    reg [15:0] len [0:3];
    reg [15:0] hold;
    reg [3:0] tc_flag;
    reg [3:0] ovr_flag;
    reg [3:0] active;
    reg [3:0] enable_d;
    wire [3:0] req_src;
    wire [3:0] pend;
    wire [3:0] term;
    wire [23:0] step_a_next;
    wire [23:0] step_b_next;
    wire cur_ind;
    wire cur_sense;
    wire item_done;
    wire last_item;
    wire cycle;

    // reset release through two flops so deassertion is clean
    always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // debug halt arrives from outside the core clock domain
    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            halt_s1 <= 1'b0;
            halt <= 1'b0;
        end else begin
            halt_s1 <= HALT_IN;
            halt <= halt_s1;
        end
    end

    // per-channel request qualification and status flags
    genvar c;
    generate
        for (c = 0; c < `FCDMA_NUM_CH; c = c + 1) begin : g_ch
            // one source selected per channel, or the software bit
            assign req_src[c] = (SRC_SEL_IN[c] ? HW_REQ_SEC_IN[c] : HW_REQ_PRI_IN[c])
                | SW_REQ_IN[c];
            assign pend[c] = CH_ENABLE_IN[c] & active[c] & req_src[c];
            assign term[c] = item_done & last_item & (cur == c);
            assign ACK_OUT[c] = (state == S_XFER | (state == S_RD & SENSE_IN[c])
                | (state == S_WR & ~SENSE_IN[c])) & (cur == c) & INDIRECT_IN[c] == 1'b0
                ? 1'b1 : 1'b0;
            assign IRQ_OUT[c] = (tc_flag[c] & DONE_IRQ_EN_IN[c])
                | (ovr_flag[c] & OVR_IRQ_EN_IN[c]);

            // terminal set beats a software clear arriving the same cycle
            always @(posedge CORE_CLK_IN or negedge rst_n) begin
                if (!rst_n) begin
                    tc_flag[c] <= 1'b0;
                    ovr_flag[c] <= 1'b0;
                    active[c] <= 1'b0;
                    enable_d[c] <= 1'b0;
                end else begin
                    enable_d[c] <= CH_ENABLE_IN[c];
                    if (term[c])
                        tc_flag[c] <= 1'b1;
                    else if (TC_CLR_IN[c])
                        tc_flag[c] <= 1'b0;
                    if (term[c])
                        ovr_flag[c] <= 1'b1;
                    else if (OVR_CLR_IN[c])
                        ovr_flag[c] <= 1'b0;
                    if (!CH_ENABLE_IN[c] || term[c])
                        active[c] <= 1'b0;
                    else if (!enable_d[c])
                        active[c] <= 1'b1;
                end
            end
        end
    endgenerate

    assign cur_ind = INDIRECT_IN[cur];
    assign cur_sense = SENSE_IN[cur];
    // an item completes at the end of a direct cycle or an indirect write
    assign item_done = (state == S_XFER) | (state == S_WR);
    // a zero length counts as one item, so a never-loaded channel still ends
    assign last_item = (len[cur] == 16'h0001) | (len[cur] == `FCDMA_LEN_RST);

    fcdma_step u_step_a (
        .addr_in(addr_a[cur]),
        .step_in(STEP_A_IN[2 * cur +: 2]),
        .adjust_in(ADJ_A_IN[cur]),
        .addr_out(step_a_next)
    );

    fcdma_step u_step_b (
        .addr_in(addr_b[cur]),
        .step_in(STEP_B_IN[2 * cur +: 2]),
        .adjust_in(ADJ_B_IN[cur]),
        .addr_out(step_b_next)
    );

    // sequencer: arbitration, priority clock, bus cycles, release
    always @* begin
        next_state = state;
        case (state)
            S_ARB: begin
                if ((|pend) && !halt && BUS_GRANT_IN)
                    next_state = S_PRI;
            end
            S_PRI: begin
                if (!(|pend) || halt)
                    next_state = S_ARB;
                else if (INDIRECT_IN[fcdma_pick(pend)])
                    next_state = S_RD;
                else
                    next_state = S_XFER;
            end
            S_RD: next_state = S_WR;
            S_XFER, S_WR: begin
                // request sampled at the edge where acknowledge drops
                if (!last_item && CONTINUOUS_IN[cur] && req_src[cur] && !halt)
                    next_state = cur_ind ? S_RD : S_XFER;
                else
                    next_state = cur_ind ? S_REL : S_ARB;
            end
            S_REL: next_state = S_ARB;
            default: next_state = S_ARB;
        endcase
    end

    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n)
            state <= S_ARB;
        else
            state <= next_state;
    end

    // channel chosen one clock before the first bus clock
    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n)
            cur <= 2'h0;
        else if (state == S_PRI)
            cur <= fcdma_pick(pend);
    end

    // holding register only used by indirect moves; direct never latches
    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n)
            hold <= `FCDMA_DATA_RST;
        else if (state == S_RD)
            hold <= ITEM16_IN[cur] ? BUS_RDATA_IN : {8'h00, BUS_RDATA_IN[7:0]};
    end

    // counters: software load wins over an update in the same cycle
    integer i;
    always @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `FCDMA_NUM_CH; i = i + 1) begin
                addr_a[i] <= `FCDMA_ADDR_RST;
                addr_b[i] <= `FCDMA_ADDR_RST;
                len[i] <= `FCDMA_LEN_RST;
            end
        end else begin
            for (i = 0; i < `FCDMA_NUM_CH; i = i + 1) begin
                if (LOAD_IN[i]) begin
                    addr_a[i] <= LOAD_ADDR_A_IN;
                    addr_b[i] <= LOAD_ADDR_B_IN;
                    len[i] <= LOAD_LEN_IN;
                end else if (item_done && cur == i) begin
                    len[i] <= len[i] - 16'h0001;
                    addr_a[i] <= step_a_next;
                    if (INDIRECT_IN[i])
                        addr_b[i] <= step_b_next;
                end
            end
        end
    end

    // strobe-carrying states; priority and release clocks carry no strobe
    assign cycle = (state == S_XFER) | (state == S_RD) | (state == S_WR);
    // bus held from arbitration through the last cycle
    assign BUS_REQ_OUT = (state == S_ARB & (|pend) & ~halt) | (state == S_PRI) | cycle;
    // address select: direct uses A only; indirect swaps with sense
    assign BUS_ADDR_OUT = (state == S_XFER) ? addr_a[cur] :
        (state == S_RD) ? (cur_sense ? addr_b[cur] : addr_a[cur]) :
        (state == S_WR) ? (cur_sense ? addr_a[cur] : addr_b[cur]) : `FCDMA_ADDR_RST;
    assign BUS_RD_OUT = (state == S_XFER & ~cur_sense) | (state == S_RD);
    assign BUS_WR_OUT = (state == S_XFER & cur_sense) | (state == S_WR);
    assign BUS_WIDE_OUT = cycle & ITEM16_IN[cur];
    assign BUS_DRIVE_OUT = (state == S_WR);
    assign BUS_WDATA_OUT = hold;
    assign TC_FLAG_OUT = tc_flag;
    assign OVR_FLAG_OUT = ovr_flag;
    assign ACTIVE_OUT = active;

endmodule

// *** bench/fcdma_bus_model.sv ***
/* bus partner: grants mastership and answers reads.
   assumes it shares the controller clock. */
module fcdma_bus_model (
    input wire clk_in,
    input wire slow_in,
    input wire req_in,
    input wire rd_in,
    input wire [23:0] addr_in,
    output wire grant_out,
    output wire [15:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    reg tick = 1'b0;
    reg [15:0] junk = 16'h0000;
    // free pattern so stale read data never looks valid
    always @(posedge clk_in) begin
        tick <= ~tick;
        junk <= junk + 16'h1357;
    end
    // slow mode grants only every other clock
    assign grant_out = req_in & (~slow_in | tick);
    assign rdata_out = rd_in ? (addr_in[15:0] ^ 16'h5A3C) : junk;
endmodule

// *** bench/fcdma_assertions.sv ***
/* port checker for the transfer controller.
   assumes one clock and all outputs low in reset. */
module fcdma_assertions (
    input wire CORE_CLK_IN,
    input wire ARST_N_IN,
    input wire HALT_IN,
    input wire [3:0] CH_ENABLE_IN,
    input wire [3:0] DONE_IRQ_EN_IN,
    input wire [3:0] OVR_IRQ_EN_IN,
    input wire BUS_GRANT_IN,
    input wire BUS_RD_OUT,
    input wire BUS_WR_OUT,
    input wire BUS_DRIVE_OUT,
    input wire [3:0] ACK_OUT,
    input wire [3:0] TC_FLAG_OUT,
    input wire [3:0] OVR_FLAG_OUT,
    input wire [3:0] ACTIVE_OUT,
    input wire [3:0] IRQ_OUT
);
    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    reg [3:0] prev_tc;
    wire cyc = BUS_RD_OUT | BUS_WR_OUT;
    wire [3:0] tc_new = TC_FLAG_OUT & ~prev_tc;
    // flag history, so a fresh terminal count shows once
    always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            prev_tc <= 4'h0;
        else
            prev_tc <= TC_FLAG_OUT;
    end
    chk_bus_won: assert property ($rose(cyc) |-> $past(BUS_GRANT_IN, 2))
        else $error("bus cycle without grant");
    chk_ack_in_cycle: assert property (ACK_OUT != 4'h0 |-> cyc && !BUS_DRIVE_OUT)
        else $error("acknowledge outside direct cycle");
    chk_ack_single: assert property ($onehot0(ACK_OUT))
        else $error("two acknowledges");
    chk_write_pair: assert property (BUS_DRIVE_OUT |-> BUS_WR_OUT && $past(BUS_RD_OUT))
        else $error("indirect write without read");
    chk_flags_pair: assert property (TC_FLAG_OUT == OVR_FLAG_OUT)
        else $error("done and overrun flags differ");
    chk_done_idle: assert property (tc_new != 4'h0 |=> (ACTIVE_OUT & $past(tc_new)) == 4'h0)
        else $error("channel still active after end");
    chk_done_release: assert property (tc_new != 4'h0 |-> !cyc [*2])
        else $error("bus kept after block end");
    chk_irq_cause: assert property (IRQ_OUT == ((TC_FLAG_OUT & DONE_IRQ_EN_IN) |
        (OVR_FLAG_OUT & OVR_IRQ_EN_IN)))
        else $error("interrupt does not follow flags and enables");
    chk_halt_quiet: assert property (HALT_IN [*7] |-> !cyc)
        else $error("bus cycle during halt");
    chk_off_no_ack: assert property ((ACK_OUT & ~CH_ENABLE_IN) == 4'h0)
        else $error("disabled channel acknowledged");
endmodule
bind fcdma_top fcdma_assertions chk (.*);

// *** bench/testbench.sv ***
/* random single-block runs checked item by item against a bench model.
   assumes the bus partner and a zero-wait bus. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK_IN = 1'b0, ARST_N_IN = 1'b0, HALT_IN = 1'b0, slow = 1'b0;
    logic [3:0] CH_ENABLE_IN = 4'h0, SRC_SEL_IN = 4'h0, HW_REQ_PRI_IN = 4'h0;
    logic [3:0] HW_REQ_SEC_IN = 4'h0, SW_REQ_IN = 4'h0, INDIRECT_IN = 4'h0;
    logic [3:0] CONTINUOUS_IN = 4'h0, SENSE_IN = 4'h0, ITEM16_IN = 4'h0;
    logic [3:0] ADJ_A_IN = 4'h0, ADJ_B_IN = 4'h0, DONE_IRQ_EN_IN = 4'h0;
    logic [3:0] OVR_IRQ_EN_IN = 4'h0, LOAD_IN = 4'h0, TC_CLR_IN = 4'h0, OVR_CLR_IN = 4'h0;
    logic [7:0] STEP_A_IN = 8'h00, STEP_B_IN = 8'h00;
    logic [23:0] LOAD_ADDR_A_IN = 24'h000000, LOAD_ADDR_B_IN = 24'h000000;
    logic [15:0] LOAD_LEN_IN = 16'h0000;
    wire BUS_GRANT_IN, BUS_REQ_OUT, BUS_RD_OUT, BUS_WR_OUT, BUS_WIDE_OUT, BUS_DRIVE_OUT;
    wire [15:0] BUS_RDATA_IN, BUS_WDATA_OUT;
    wire [23:0] BUS_ADDR_OUT;
    wire [3:0] ACK_OUT, TC_FLAG_OUT, OVR_FLAG_OUT, ACTIVE_OUT, IRQ_OUT;
    int fail_count = 0, checks = 0, cycles = 0, seed = 17819, t;
    fcdma_top dut (.*);
    fcdma_bus_model partner (.clk_in(CORE_CLK_IN), .slow_in(slow), .req_in(BUS_REQ_OUT),
        .rd_in(BUS_RD_OUT), .addr_in(BUS_ADDR_OUT), .grant_out(BUS_GRANT_IN),
        .rdata_out(BUS_RDATA_IN));
    always #4 CORE_CLK_IN = ~CORE_CLK_IN;
    // hang guard, far above the longest run set
    always @(posedge CORE_CLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // pointer step model; clear adjust freezes it
    function automatic logic [23:0] nx(input logic [23:0] a, input logic [1:0] s, input logic e);
        nx = a + {22'h000000, s[0], ~s[0]};
        if (s[1])
            nx = a - {22'h000000, s[0], ~s[0]};
        if (!e)
            nx = a;
    endfunction
    // drop requests, disable, clear flags with one pulse
    task automatic stop(input logic [3:0] m);
        CH_ENABLE_IN = 4'h0;
        SW_REQ_IN = 4'h0;
        {HW_REQ_SEC_IN, HW_REQ_PRI_IN} = 8'h00;
        {TC_CLR_IN, OVR_CLR_IN} = {m, m};
        @(negedge CORE_CLK_IN);
        {TC_CLR_IN, OVR_CLR_IN} = 8'h00;
        @(negedge CORE_CLK_IN);
        chk({TC_FLAG_OUT, IRQ_OUT}, 8'h00);
    endtask
    task automatic run(input int c, input logic [15:0] r, input int len);
        logic [23:0] a, b, e;
        logic [15:0] hold;
        logic [3:0] m;
        logic hw;
        int n, k, ph, last;
        m = 4'h1 << c;
        a = 24'($random(seed));
        b = 24'($random(seed));
        n = (len == 0) ? 1 : len;
        k = 0;
        ph = 0;
        last = 0;
        hw = r[10] & ~r[0];
        HALT_IN = r[15];
        repeat (3) @(negedge CORE_CLK_IN);
        {INDIRECT_IN, CONTINUOUS_IN, SENSE_IN, ITEM16_IN} = {{4{r[0]}}, {4{r[1]}}, {4{r[2]}}, {4{r[3]}}};
        {STEP_A_IN, ADJ_A_IN, STEP_B_IN, ADJ_B_IN} = {{4{r[5:4]}}, {4{r[6]}}, {4{r[8:7]}}, {4{r[9]}}};
        {SRC_SEL_IN, DONE_IRQ_EN_IN, OVR_IRQ_EN_IN} = {{4{r[11]}}, {4{r[13]}}, {4{r[14]}}};
        slow = r[12];
        // software loads counters before enabling
        {LOAD_IN, LOAD_ADDR_A_IN, LOAD_ADDR_B_IN, LOAD_LEN_IN} = {m, a, b, len[15:0]};
        @(negedge CORE_CLK_IN);
        LOAD_IN = 4'h0;
        CH_ENABLE_IN = m;
        // one source per channel, memory copies by software only
        {HW_REQ_SEC_IN, HW_REQ_PRI_IN} = !hw ? 8'h00 : r[11] ? {m, 4'h0} : {4'h0, m};
        SW_REQ_IN = hw ? 4'h0 : m;
        for (t = 1; t < 12 * n + 30; t++) begin
            @(negedge CORE_CLK_IN);
            // only a halted run must still be idle here
            if (t == 10 && HALT_IN)
                chk(k, 0);
            if (t == 10 && HALT_IN)
                chk(BUS_REQ_OUT, 1'b0);
            if (t == 10)
                HALT_IN = 1'b0;
            if (BUS_RD_OUT | BUS_WR_OUT) begin
                if (k == n)
                    chk(32'h1, 32'h0);
                if (ph == 0) begin
                    if (k > 0 && !slow)
                        chk(t - last, r[0] ? (r[1] ? 2 : 5) : (r[1] ? 1 : 3));
                    last = t;
                    e = (r[0] & r[2]) ? b : a;
                    chk({BUS_RD_OUT, BUS_WR_OUT, BUS_WIDE_OUT, ACK_OUT},
                        {r[0] | ~r[2], ~r[0] & r[2], r[3], r[0] ? 4'h0 : m});
                    chk(BUS_ADDR_OUT, e);
                    hold = r[3] ? (e[15:0] ^ 16'h5A3C) : {8'h00, e[7:0] ^ 8'h3C};
                    ph = r[0];
                end else begin
                    chk({BUS_WR_OUT, BUS_DRIVE_OUT, BUS_WDATA_OUT}, {2'h3, hold});
                    chk(BUS_ADDR_OUT, r[2] ? a : b);
                    ph = 0;
                end
                if (ph == 0) begin
                    k++;
                    a = nx(a, r[5:4], r[6]);
                    b = r[0] ? nx(b, r[8:7], r[9]) : b;
                end
            end
        end
        chk(k, n);
        chk({TC_FLAG_OUT[c], OVR_FLAG_OUT[c], ACTIVE_OUT[c], IRQ_OUT[c]}, {3'h6, r[13] | r[14]});
        stop(m);
    endtask
    initial begin
        repeat (4) @(negedge CORE_CLK_IN);
        ARST_N_IN = 1'b1;
        repeat (3) @(negedge CORE_CLK_IN);
        // requests on disabled channels win nothing
        SW_REQ_IN = 4'hF;
        repeat (8) @(negedge CORE_CLK_IN);
        chk({BUS_REQ_OUT, ACTIVE_OUT}, 5'h00);
        // two channels at once: lowest number served first
        CH_ENABLE_IN = 4'h5;
        SW_REQ_IN = 4'h5;
        for (t = 0; t < 20 && !(BUS_RD_OUT | BUS_WR_OUT); t++)
            @(negedge CORE_CLK_IN);
        chk(ACK_OUT, 4'h1);
        repeat (20) @(negedge CORE_CLK_IN);
        stop(4'hF);
        repeat (40) run($random(seed) & 3, 16'($random(seed)), $random(seed) & 3);
        end_of_test();
    end
endmodule
